// ==== ddt_pkg.sv ====
// ddt_pkg: constants and types for the dual trigger-controlled converter.
// assumes a Wishbone classic slave with 32-bit data and byte addresses.
//
// Summary of operation
// [R1] two independent channels, each converting an eight-bit code to one level
// [R2] normal mode: a value write updates that channel's output at once
// [R3] real-time mode: channel 0 updates on timer 1, channel 1 on timer 2
// [R4] real-time mode: a newly written code waits hidden until the next trigger
// [R5] software writes the next code between one trigger and the next
// [R6] mode bit 4 selects real-time mode for channel 0
// [R7] software writes zero to reserved mode bits 2, 3, 6 and 7
// [R8] a disabled channel leaves its output in high impedance
// [R9] output level is reference times code divided by 256
// [R10] output latch resets to zero, so real-time start shows zero first
// [R11] software preloads in normal mode before enabling real-time and timers
// [R12] software sets shared port pins as inputs without pull-ups
// [R13] mode bit 0 enables channel 0 conversion
// [R14] each channel keeps separate value and output latches
package ddt_pkg;
    // =========================================================
    // register map
    localparam logic [3:0] DDT_ADR_VALUE0 = 4'h0;
    localparam logic [3:0] DDT_ADR_VALUE1 = 4'h4;
    localparam logic [3:0] DDT_ADR_MODE = 4'h8;
    localparam logic [3:0] DDT_ADR_OUT = 4'hC;
    // =========================================================
    // mode register fields
    localparam int DDT_BIT_EN0 = 0;
    localparam int DDT_BIT_EN1 = 1;
    localparam int DDT_BIT_RT0 = 4;
    localparam int DDT_BIT_RT1 = 5;
    localparam logic [7:0] DDT_MODE_WMASK = 8'h33;
    localparam logic [7:0] DDT_MODE_RST = 8'h00;
    localparam logic [7:0] DDT_CODE_RST = 8'h00;
    localparam int DDT_FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        DDT_IDLE = 3'b001,
        DDT_ACK = 3'b010,
        DDT_HOLD = 3'b100
    } ddt_bus_state_t;
endpackage : ddt_pkg

// ==== ddt_fifo_if.sv ====
// ddt_fifo_if: valid/ready stream carrying channel-tagged codes.
// assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface ddt_fifo_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ddt_fifo_if

// ==== ddt_fifo.sv ====
// ddt_fifo: synchronous FIFO with valid/ready on both sides.
// assumes one clock, synchronous active-high reset, clock enable.
`timescale 1ns/1ps
module ddt_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    ddt_fifo_if.snk in_if,
    ddt_fifo_if.src out_if
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("ddt_fifo: depth must be a power of two >= 2");
    end
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } ddt_fifo_st_t;
    ddt_fifo_st_t st_r;
    ddt_fifo_st_t st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign full = (st_r.wp[AW] != st_r.rp[AW]) &&
                  (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
    assign empty = (st_r.wp == st_r.rp);
    assign in_if.ready = !full;
    assign out_if.valid = !empty;
    assign out_if.data = mem[st_r.rp[AW-1:0]];
    assign push = in_if.valid && !full && ce_i;
    assign pop = out_if.ready && !empty && ce_i;

    always_comb begin
        st_nxt = st_r;
        if (push)
            st_nxt.wp = st_r.wp + 1'b1;
        if (pop)
            st_nxt.rp = st_r.rp + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            st_r <= '0;
        else if (ce_i)
            st_r <= st_nxt;
        if (push)
            mem[st_r.wp[AW-1:0]] <= in_if.data;
    end
endmodule : ddt_fifo

// ==== ddt_dac_ctrl.sv ====
// ddt_dac_ctrl: two-channel 8-bit converter control with timer triggers.
// assumes Wishbone classic master, timer events as one-cycle pulses,
// and an external analog stage fed by the code and enable outputs.
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module ddt_dac_ctrl #(
    parameter int FIFO_DEPTH = ddt_pkg::DDT_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic timer1_match_event_i,
    input wire logic timer2_match_event_i,
    output logic [7:0] analog_out_ch0_o,
    output logic [7:0] analog_out_ch1_o,
    output logic analog_out_ch0_oe_n_o,
    output logic analog_out_ch1_oe_n_o
);
    import ddt_pkg::*;

    // =========================================================
    // state
    typedef struct packed {
        ddt_bus_state_t bus;
        logic [7:0] mode;
        logic [1:0][7:0] value;
        logic [1:0][7:0] out;
        logic [31:0] rdat;
        logic ack;
        logic err;
        logic [1:0] oe_n;
    } ddt_st_t;

    ddt_st_t st_r;
    ddt_st_t st_nxt;

    ddt_fifo_if #(.W(9)) wr_in ();
    ddt_fifo_if #(.W(9)) wr_out ();

    ddt_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_if(wr_in.snk),
        .out_if(wr_out.src)
    );

    logic req;
    logic [3:0] adr;
    logic wr_val;
    logic adr_ok;
    logic [1:0] trig;
    logic [1:0] en;
    logic [1:0] rt;
    logic [7:0] wbyte;

    assign req = wb_cyc_i && wb_stb_i;
    assign adr = wb_adr_i[3:0];
    assign adr_ok = (adr == DDT_ADR_VALUE0) || (adr == DDT_ADR_VALUE1) ||
                    (adr == DDT_ADR_MODE) || (adr == DDT_ADR_OUT);
    assign wr_val = wb_we_i && wb_sel_i[0] &&
                    ((adr == DDT_ADR_VALUE0) || (adr == DDT_ADR_VALUE1));
    assign wbyte = wb_dat_i[7:0];
    assign trig = {timer2_match_event_i, timer1_match_event_i}; // [R3]
    assign en = {st_r.mode[DDT_BIT_EN1], st_r.mode[DDT_BIT_EN0]}; // [R13]
    assign rt = {st_r.mode[DDT_BIT_RT1], st_r.mode[DDT_BIT_RT0]}; // [R6]

    // value writes queue through the fifo; a full fifo stalls the ack
    assign wr_in.valid = (st_r.bus == DDT_IDLE) && req && wr_val && adr_ok;
    assign wr_in.data = {(adr == DDT_ADR_VALUE1), wbyte};
    assign wr_out.ready = 1'b1;

    // =========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.err = 1'b0;
        unique case (st_r.bus)
            DDT_IDLE: begin
                if (req && (!wr_val || wr_in.ready)) begin
                    st_nxt.bus = DDT_ACK;
                    st_nxt.ack = adr_ok;
                    st_nxt.err = !adr_ok;
                    st_nxt.rdat = '0;
                    if (adr_ok && !wb_we_i) begin
                        unique case (adr)
                            DDT_ADR_VALUE0: st_nxt.rdat[7:0] = st_r.value[0];
                            DDT_ADR_VALUE1: st_nxt.rdat[7:0] = st_r.value[1];
                            DDT_ADR_MODE: st_nxt.rdat[7:0] = st_r.mode;
                            default: st_nxt.rdat[15:0] = st_r.out;
                        endcase
                    end
                    if (adr_ok && wb_we_i && wb_sel_i[0] &&
                        adr == DDT_ADR_MODE) begin
                        // reserved bits kept at zero regardless of write
                        st_nxt.mode = wbyte & DDT_MODE_WMASK; // [R7]
                    end
                end
            end
            DDT_ACK: st_nxt.bus = DDT_HOLD;
            DDT_HOLD: begin
                if (!req)
                    st_nxt.bus = DDT_IDLE;
            end
        endcase

        for (int c = 0; c < 2; c++) begin
            // trigger loads the latched code into the output [R3]
            if (rt[c] && trig[c]) begin
                st_nxt.out[c] = st_r.value[c]; // [R4]
            end
        end
        if (wr_out.valid) begin
            for (int c = 0; c < 2; c++) begin
                if (wr_out.data[8] == c[0]) begin
                    st_nxt.value[c] = wr_out.data[7:0]; // [R14]
                    // real-time mode leaves the code hidden until trigger [R4]
                    if (!rt[c])
                        st_nxt.out[c] = wr_out.data[7:0]; // [R2]
                end
            end
        end
        st_nxt.oe_n = ~en; // [R8]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.bus <= DDT_IDLE;
            st_r.mode <= DDT_MODE_RST;
            st_r.value <= {2{DDT_CODE_RST}};
            st_r.out <= {2{DDT_CODE_RST}}; // [R10]
            st_r.rdat <= '0;
            st_r.ack <= 1'b0;
            st_r.err <= 1'b0;
            st_r.oe_n <= 2'b11;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // =========================================================
    // outputs; the code drives an external ladder: ref*code/256 [R9] [R1]
    assign wb_dat_o = st_r.rdat;
    assign wb_ack_o = st_r.ack;
    assign wb_err_o = st_r.err;
    assign analog_out_ch0_o = st_r.out[0];
    assign analog_out_ch1_o = st_r.out[1];
    assign analog_out_ch0_oe_n_o = st_r.oe_n[0];
    assign analog_out_ch1_oe_n_o = st_r.oe_n[1];
endmodule : ddt_dac_ctrl

// ==== ddt_filter_model.sv ====
// ddt_filter_model: level one output pin hands the smoothing filter.
// assumes an ideal reference; a floating pin reports -1.
`timescale 1ns/1ps
module ddt_filter_model #(
    parameter int REF_MV = 5000
) (
    input wire logic [7:0] code_i,
    input wire logic oe_n_i,
    output int level_mv_o
);
    // ======
    // shared pin is an input with no pull-up, so a float has no level
    assign level_mv_o = oe_n_i ? -1
        : REF_MV * int'(code_i) / 256;
endmodule : ddt_filter_model

// ==== ddt_dac_ctrl_chk.sv ====
// ddt_dac_ctrl_chk: port assertions for the converter control.
// assumes sel[0] set on every write; frozen cycles are not checked.
`timescale 1ns/1ps
module ddt_dac_ctrl_chk
    import ddt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic timer1_match_event_i,
    input wire logic timer2_match_event_i,
    input wire logic [7:0] analog_out_ch0_o,
    input wire logic [7:0] analog_out_ch1_o,
    input wire logic analog_out_ch0_oe_n_o,
    input wire logic analog_out_ch1_oe_n_o
);
    // ======
    // shadow of what software wrote
    wire logic w = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire logic w0 = w && wb_adr_i[3:0] == DDT_ADR_VALUE0;
    wire logic w1 = w && wb_adr_i[3:0] == DDT_ADR_VALUE1;
    wire logic wm = w && wb_adr_i[3:0] == DDT_ADR_MODE;
    wire logic t1 = timer1_match_event_i;
    wire logic t2 = timer2_match_event_i;
    wire logic [7:0] o0 = analog_out_ch0_o;
    wire logic [7:0] o1 = analog_out_ch1_o;
    logic [7:0] md_r;
    logic [7:0] v0_r;
    logic [7:0] v1_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            md_r <= DDT_MODE_RST;
            v0_r <= DDT_CODE_RST;
            v1_r <= DDT_CODE_RST;
        end else begin
            md_r <= wm ? wb_dat_i[7:0] & DDT_MODE_WMASK : md_r;
            v0_r <= w0 ? wb_dat_i[7:0] : v0_r;
            v1_r <= w1 ? wb_dat_i[7:0] : v1_r;
        end
    end
    // ======
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    // a low clock enable freezes everything, so no rule applies then
    default disable iff (rst_i || !ce_i);
    sequence s_quiet0;
        (!wb_ack_o && !t1) [*4];
    endsequence
    sequence s_settled;
        !wm ##1 !wm ##1 !wm;
    endsequence
    property p_rst_zero;
        $fell(rst_i) |-> o0 == 8'h00 && o1 == 8'h00
            && analog_out_ch0_oe_n_o && analog_out_ch1_oe_n_o;
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("outputs not cleared");
    property p_quiet0;
        s_quiet0 |=> $stable(o0);
    endproperty
    a_quiet0: assert property (p_quiet0)
        else $error("ch0 moved without cause");
    property p_norm0;
        w0 && !md_r[DDT_BIT_RT0] |-> ##[1:3] o0 == v0_r;
    endproperty
    a_norm0: assert property (p_norm0)
        else $error("ch0 write not shown");
    property p_norm1;
        w1 && !md_r[DDT_BIT_RT1] |-> ##[1:3] o1 == v1_r;
    endproperty
    a_norm1: assert property (p_norm1)
        else $error("ch1 write not shown");
    property p_trig0;
        t1 && md_r[DDT_BIT_RT0] && !w0 && !$past(w0) && !$past(w0, 2)
            |=> o0 == v0_r;
    endproperty
    a_trig0: assert property (p_trig0)
        else $error("ch0 trigger load wrong");
    property p_trig1;
        t2 && md_r[DDT_BIT_RT1] && !w1 && !$past(w1) && !$past(w1, 2)
            |=> o1 == v1_r;
    endproperty
    a_trig1: assert property (p_trig1)
        else $error("ch1 trigger load wrong");
    property p_en0;
        s_settled |-> analog_out_ch0_oe_n_o != md_r[DDT_BIT_EN0];
    endproperty
    a_en0: assert property (p_en0)
        else $error("ch0 enable wrong");
    property p_en1;
        s_settled |-> analog_out_ch1_oe_n_o != md_r[DDT_BIT_EN1];
    endproperty
    a_en1: assert property (p_en1)
        else $error("ch1 enable wrong");
endmodule : ddt_dac_ctrl_chk
bind ddt_dac_ctrl ddt_dac_ctrl_chk u_ddt_dac_ctrl_chk (
    .clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_sel_i, .wb_we_i, .wb_dat_i,
    .wb_ack_o,
    .timer1_match_event_i, .timer2_match_event_i,
    .analog_out_ch0_o, .analog_out_ch1_o,
    .analog_out_ch0_oe_n_o, .analog_out_ch1_oe_n_o
);

// ==== ddt_dac_ctrl_tb.sv ====
// ddt_dac_ctrl_tb: register-level tests of the converter control.
// assumes the checker is bound in; ce_i drops once to freeze a trigger.
`timescale 1ns/1ps
module ddt_dac_ctrl_tb;
    import ddt_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = 4'hF;
    logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic timer1_match_event_i = 1'b0, timer2_match_event_i = 1'b0;
    logic wb_ack_o, wb_err_o, er;
    logic [7:0] analog_out_ch0_o, analog_out_ch1_o;
    logic analog_out_ch0_oe_n_o, analog_out_ch1_oe_n_o;
    int mv0, mv1, num_errors = 0, num_checks = 0, cyc_n = 0;
    wire logic [31:0] pins = {14'h0000, analog_out_ch1_oe_n_o,
        analog_out_ch0_oe_n_o, analog_out_ch1_o, analog_out_ch0_o};
    ddt_dac_ctrl u_ddt_dac_ctrl (.clk_i, .rst_i, .ce_i, .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
        .wb_ack_o, .wb_err_o, .timer1_match_event_i, .timer2_match_event_i,
        .analog_out_ch0_o, .analog_out_ch1_o, .analog_out_ch0_oe_n_o,
        .analog_out_ch1_oe_n_o);
    ddt_filter_model u_ddt_filter_model_0 (.code_i(analog_out_ch0_o),
        .oe_n_i(analog_out_ch0_oe_n_o), .level_mv_o(mv0));
    ddt_filter_model u_ddt_filter_model_1 (.code_i(analog_out_ch1_o),
        .oe_n_i(analog_out_ch1_oe_n_o), .level_mv_o(mv1));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic stop_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    // a hung handshake ends the run here
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_mv(input int g, input int e);
        num_checks++;
        if (g != e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_mv
    task automatic bus(input logic [3:0] a, input logic w,
        input logic [7:0] d);
        @(posedge clk_i);
        wb_adr_i <= {28'h0000000, a};
        wb_we_i <= w;
        wb_dat_i <= {24'h000000, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus
    // three edges cover the value fifo and the output latch
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
        repeat (3) @(posedge clk_i);
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(a, 1'b0, 8'h00);
        chk(rd, e);
    endtask : rdchk
    task automatic fire(input logic c2);
        @(posedge clk_i);
        timer1_match_event_i <= !c2;
        timer2_match_event_i <= c2;
        @(posedge clk_i);
        timer1_match_event_i <= 1'b0;
        timer2_match_event_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask : fire
    task automatic do_reset(input int n);
        rst_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset
    initial begin
        do_reset(12);
        chk(pins, 32'h0003_0000);
        chk_mv(mv0, -1);
        rdchk(DDT_ADR_OUT, 32'h0000_0000);
        wr(DDT_ADR_MODE, 8'h03);
        wr(DDT_ADR_VALUE0, 8'h80);
        wr(DDT_ADR_VALUE1, 8'hFF);
        chk(pins, 32'h0000_FF80);
        chk_mv(mv0, 2500);
        chk_mv(mv1, 4980);
        wr(DDT_ADR_MODE, 8'h33);
        rdchk(DDT_ADR_MODE, 32'h0000_0033);
        wr(DDT_ADR_VALUE0, 8'h9B);
        wr(DDT_ADR_VALUE1, 8'h65);
        chk(pins, 32'h0000_FF80);
        rdchk(DDT_ADR_VALUE0, 32'h0000_009B);
        fire(1'b1);
        chk(pins, 32'h0000_6580);
        fire(1'b0);
        chk(pins, 32'h0000_659B);
        wr(DDT_ADR_MODE, 8'h00);
        chk(pins, 32'h0003_659B);
        chk_mv(mv1, -1);
        bus(4'h2, 1'b1, 8'h00);
        chk({31'h0, er}, 32'h0000_0001);
        do_reset(3);
        wr(DDT_ADR_MODE, 8'h11);
        wr(DDT_ADR_VALUE0, 8'h80);
        chk(pins, 32'h0002_0000);
        fire(1'b0);
        chk(pins, 32'h0002_0080);
        wr(DDT_ADR_VALUE0, 8'h9B);
        // a frozen block must let this trigger pass unseen
        ce_i <= 1'b0;
        fire(1'b0);
        ce_i <= 1'b1;
        chk(pins, 32'h0002_0080);
        fire(1'b0);
        chk(pins, 32'h0002_009B);
        stop_test();
    end
endmodule : ddt_dac_ctrl_tb
